// File: core/dcie_pkg.sv
// constants and types for the dual channel interleave and ecc block
package dcie_pkg;
   localparam int ADDR_W = 35;          // 32 GB of byte addresses
   localparam int SLOT_ADDR_W = 33;     // 8 GB per module
   localparam int LINE_LSB = 6;         // 64-byte cache line
   localparam int DATA_W = 64;
   localparam int CHECK_W = 8;
   localparam int GROUP_W = 72;
   localparam int NUM_SLOTS = 4;
   localparam int CE_CNT_W = 4;
   localparam logic [3:0] CE_THRESHOLD = 4'ha;
   localparam logic [3:0] CE_CNT_RESET = 4'h0;
   // slot index within the population vector
   localparam int SLOT_A1 = 0;
   localparam int SLOT_A2 = 1;
   localparam int SLOT_B1 = 2;
   localparam int SLOT_B2 = 3;
   typedef enum logic [1:0] {
      DCIE_MODE_NONE = 2'b00,
      DCIE_MODE_SINGLE = 2'b01,
      DCIE_MODE_SYMMETRIC = 2'b10,
      DCIE_MODE_SPLIT = 2'b11
   } dcie_mode_t;
   typedef enum logic [1:0] {
      DCIE_ST_INIT = 2'b00,
      DCIE_ST_SCRUB = 2'b01,
      DCIE_ST_RUN = 2'b10
   } dcie_state_t;
endpackage : dcie_pkg

// File: core/dcie_ce_counter.sv
// per-module correctable error tally with threshold event
`timescale 1ns/1ps
`default_nettype none
module dcie_ce_counter (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_ce,
   output logic o_event
);
   logic [3:0] count;
   logic [3:0] next_count;
   logic next_event;
   logic ev;

   always_comb begin
      next_count = count;
      next_event = 1'b0;
      if (i_ce) begin
         if (count == dcie_pkg::CE_THRESHOLD - 4'h1) begin
            next_count = dcie_pkg::CE_CNT_RESET;
            next_event = 1'b1;
         end else begin
            next_count = count + 4'h1;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         count <= dcie_pkg::CE_CNT_RESET;
         ev <= 1'b0;
      end else begin
         count <= next_count;
         ev <= next_event;
      end
   end

   assign o_event = ev;

   chk_threshold_event: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_event |-> $past(count) == dcie_pkg::CE_THRESHOLD - 4'h1)
      else $error("threshold event without nine prior errors");
   chk_counter_restart: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_event |-> count == dcie_pkg::CE_CNT_RESET)
      else $error("counter not cleared after event");
   chk_silent_count: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_ce && count < dcie_pkg::CE_THRESHOLD - 4'h1) |=> !o_event && count == $past(count) + 4'h1)
      else $error("correctable error not tallied silently");
endmodule : dcie_ce_counter
`default_nettype wire

// File: core/dcie_ctrl.sv
// request mapping, secded check code and error events for two channels
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - channels independent, a lone module works only in slot A1 or B1
// - one populated channel means no interleave
// - equal channels alternate 64-byte lines A,B
// - unequal channels interleave to smaller, rest linear
// - decode up to 8 GB modules, 32 GB total
// - store 64 data bits plus 8 check
// - detect single and double, correct single
// - zero fill memory before checking enabled
// - return corrected word on single error
// - double error uncorrected; every error signals event
// - count correctable errors per slot silently
module dcie_ctrl (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [3:0] i_slot_present,
   input wire logic [1:0] i_size_log2,
   input wire logic i_init_start,
   output logic o_init_done,
   output logic o_config_error,
   output logic [1:0] o_mode,
   input wire logic i_req_valid,
   input wire logic i_req_write,
   input wire logic [34:0] i_req_addr,
   input wire logic [63:0] i_req_wdata,
   output logic o_req_ready,
   output logic o_mem_valid,
   output logic o_mem_write,
   output logic o_mem_chan_b,
   output logic o_mem_second_slot,
   output logic [32:0] o_mem_addr,
   output logic [71:0] o_mem_wgroup,
   input wire logic i_mem_rvalid,
   input wire logic [71:0] i_mem_rgroup,
   input wire logic [1:0] i_mem_rslot,
   output logic o_rsp_valid,
   output logic [63:0] o_rsp_data,
   output logic o_ce_pulse,
   output logic o_ue_pulse,
   output logic [3:0] o_ce_logged
);
   // sync the slot straps: they come from presence pins
   logic [3:0] pres_meta;
   logic [3:0] pres;
   logic [1:0] size_meta;
   logic [1:0] size_l2;
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         pres_meta <= 4'h0;
         pres <= 4'h0;
         size_meta <= 2'h0;
         size_l2 <= 2'h0;
      end else begin
         pres_meta <= i_slot_present;
         pres <= pres_meta;
         size_meta <= i_size_log2;
         size_l2 <= size_meta;
      end
   end

   // module size is 1 GB shl size_l2; all modules assumed alike
   logic [1:0] cnt_a;
   logic [1:0] cnt_b;
   logic bad_pop;
   dcie_pkg::dcie_mode_t mode;
   always_comb begin
      cnt_a = {1'b0, pres[dcie_pkg::SLOT_A1]} + {1'b0, pres[dcie_pkg::SLOT_A2]};
      cnt_b = {1'b0, pres[dcie_pkg::SLOT_B1]} + {1'b0, pres[dcie_pkg::SLOT_B2]};
      bad_pop = (pres[dcie_pkg::SLOT_A2] && !pres[dcie_pkg::SLOT_A1]) ||
                (pres[dcie_pkg::SLOT_B2] && !pres[dcie_pkg::SLOT_B1]);
      if (bad_pop || (cnt_a == 2'd0 && cnt_b == 2'd0))
         mode = dcie_pkg::DCIE_MODE_NONE;
      else if (cnt_a == 2'd0 || cnt_b == 2'd0)
         mode = dcie_pkg::DCIE_MODE_SINGLE;
      else if (cnt_a == cnt_b)
         mode = dcie_pkg::DCIE_MODE_SYMMETRIC;
      else
         mode = dcie_pkg::DCIE_MODE_SPLIT;
   end

   // init sequence: zero every location before checking is trusted
   dcie_pkg::dcie_state_t state;
   dcie_pkg::dcie_state_t next_state;
   logic [28:0] scrub_line;
   logic [28:0] next_scrub_line;
   logic [28:0] scrub_last;
   always_comb begin
      // installed lines = modules * 2^(24+size_l2) lines, minus one
      scrub_last = 29'(((({27'h0, cnt_a} + {27'h0, cnt_b}) << (24 + size_l2))) - 29'h1);
      next_state = state;
      next_scrub_line = scrub_line;
      case (state)
         dcie_pkg::DCIE_ST_INIT: begin
            if (i_init_start && mode != dcie_pkg::DCIE_MODE_NONE) begin
               next_state = dcie_pkg::DCIE_ST_SCRUB;
               next_scrub_line = 29'h0;
            end
         end
         dcie_pkg::DCIE_ST_SCRUB: begin
            next_scrub_line = scrub_line + 29'h1;
            if (scrub_line == scrub_last)
               next_state = dcie_pkg::DCIE_ST_RUN;
         end
         dcie_pkg::DCIE_ST_RUN: next_state = dcie_pkg::DCIE_ST_RUN;
         default: next_state = dcie_pkg::DCIE_ST_INIT;
      endcase
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state <= dcie_pkg::DCIE_ST_INIT;
         scrub_line <= 29'h0;
      end else begin
         state <= next_state;
         scrub_line <= next_scrub_line;
      end
   end

   // address decode, one scrub word per line is enough for a zero fill model
   logic running;
   logic scrubbing;
   logic [34:0] addr;
   logic [28:0] line;
   logic [28:0] lines_per_mod;
   logic [28:0] small_lines;
   logic [28:0] lin;
   logic chan_b;
   logic [28:0] chan_line;
   logic a_bigger;
   always_comb begin
      running = state == dcie_pkg::DCIE_ST_RUN;
      scrubbing = state == dcie_pkg::DCIE_ST_SCRUB;
      addr = scrubbing ? {scrub_line, 6'h0} : i_req_addr;
      line = addr[34:dcie_pkg::LINE_LSB];
      lines_per_mod = 29'h0100_0000 << size_l2;
      a_bigger = cnt_a > cnt_b;
      small_lines = (a_bigger ? {27'h0, cnt_b} : {27'h0, cnt_a}) * lines_per_mod;
      lin = line;
      chan_b = 1'b0;
      case (mode)
         dcie_pkg::DCIE_MODE_SINGLE: begin
            chan_b = cnt_a == 2'd0;
            chan_line = line;
         end
         dcie_pkg::DCIE_MODE_SYMMETRIC: begin
            chan_b = line[0];
            chan_line = {1'b0, line[28:1]};
         end
         dcie_pkg::DCIE_MODE_SPLIT: begin
            if (line < 29'(small_lines << 1)) begin
               chan_b = line[0];
               chan_line = {1'b0, line[28:1]};
            end else begin
               lin = line - small_lines;
               chan_b = !a_bigger;
               chan_line = lin;
            end
         end
         default: chan_line = line;
      endcase
   end

   // data bit i takes the i-th code from 9 up that is not a power of two:
   // powers of two belong to the check bits, so a check flip never hits data
   function automatic logic [6:0] dcie_code(input int i);
      return 7'(i + 9 + (i >= 7 ? 1 : 0) + (i >= 22 ? 1 : 0) + (i >= 53 ? 1 : 0));
   endfunction : dcie_code

   // hamming secded encode over 64 bits
   function automatic logic [7:0] dcie_syndrome(input logic [63:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (d[i]) c[6:0] = c[6:0] ^ dcie_code(i);
      end
      c[7] = ^d ^ ^c[6:0];
      return c;
   endfunction : dcie_syndrome

   logic [63:0] wdata;
   always_comb begin
      wdata = scrubbing ? 64'h0000_0000_0000_0000 : i_req_wdata;
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_mem_valid <= 1'b0;
         o_mem_write <= 1'b0;
         o_mem_chan_b <= 1'b0;
         o_mem_second_slot <= 1'b0;
         o_mem_addr <= 33'h0;
         o_mem_wgroup <= 72'h0;
      end else begin
         o_mem_valid <= scrubbing || (running && i_req_valid);
         o_mem_write <= scrubbing || i_req_write;
         o_mem_chan_b <= chan_b;
         o_mem_second_slot <= chan_line >= lines_per_mod;
         o_mem_addr <= {chan_line[26:0], 6'h0};
         o_mem_wgroup <= {dcie_syndrome(wdata), wdata};
      end
   end

   // read check: syndrome low bits name the flipped position
   logic [7:0] syn;
   logic [7:0] recalc;
   logic [63:0] fixed;
   logic ce;
   logic ue;
   always_comb begin
      recalc = dcie_syndrome(i_mem_rgroup[63:0]);
      // overall parity over the whole group as read, stored parity bit included
      syn = {^i_mem_rgroup, recalc[6:0] ^ i_mem_rgroup[70:64]};
      fixed = i_mem_rgroup[63:0];
      for (int i = 0; i < 64; i++) begin
         if (syn[6:0] == dcie_code(i) && syn[7]) fixed[i] = !fixed[i];
      end
      ce = i_mem_rvalid && syn[7];
      ue = i_mem_rvalid && !syn[7] && syn[6:0] != 7'h00;
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_rsp_valid <= 1'b0;
         o_rsp_data <= 64'h0;
         o_ce_pulse <= 1'b0;
         o_ue_pulse <= 1'b0;
      end else begin
         o_rsp_valid <= i_mem_rvalid;
         o_rsp_data <= ue ? i_mem_rgroup[63:0] : fixed;
         o_ce_pulse <= ce;
         o_ue_pulse <= ue;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_slot
         dcie_ce_counter u_cnt (
            .i_clock(i_clock),
            .i_rst_n(i_rst_n),
            .i_ce(ce && i_mem_rslot == 2'(g)),
            .o_event(o_ce_logged[g])
         );
      end
   endgenerate

   assign o_req_ready = running;
   assign o_init_done = running;
   assign o_config_error = bad_pop;
   assign o_mode = mode;

   chk_ue_event: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ue |=> o_ue_pulse && o_rsp_data == $past(i_mem_rgroup[63:0]))
      else $error("double error not flagged or data altered");
   chk_ce_event: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ce |=> o_ce_pulse && !o_ue_pulse)
      else $error("single error not flagged");
   chk_clean_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_mem_rvalid && syn == 8'h00) |=> o_rsp_data == $past(i_mem_rgroup[63:0]) && !o_ce_pulse)
      else $error("clean read altered");
   chk_sym_alt: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (running && i_req_valid && mode == dcie_pkg::DCIE_MODE_SYMMETRIC) |=> o_mem_chan_b == $past(i_req_addr[6]))
      else $error("symmetric lines not alternating");
   chk_single_chan: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (running && i_req_valid && mode == dcie_pkg::DCIE_MODE_SINGLE) |=> o_mem_chan_b == $past(cnt_a == 2'd0))
      else $error("single channel went to empty channel");
   chk_scrub_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      scrubbing |=> o_mem_write && o_mem_wgroup == 72'h0)
      else $error("init fill not zero");
   chk_no_req_early: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (!running && !scrubbing) |=> !o_mem_valid)
      else $error("memory access before init");
   chk_bad_pop: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_config_error |-> mode == dcie_pkg::DCIE_MODE_NONE)
      else $error("invalid population given a mode");
endmodule : dcie_ctrl
`default_nettype wire

// File: dv/dcie_dimm_model.sv
// behavioural model of the ecc modules on both channels
`timescale 1ns/1ps
`default_nettype none
module dcie_dimm_model (
   input wire logic i_clock,
   input wire logic i_valid,
   input wire logic i_write,
   input wire logic i_chan_b,
   input wire logic i_second,
   input wire logic [32:0] i_addr,
   input wire logic [71:0] i_wgroup,
   input wire logic [3:0] i_delay,
   input wire logic [71:0] i_flip,
   input wire logic i_inj,
   input wire logic [1:0] i_inj_slot,
   output logic o_rvalid,
   output logic [71:0] o_rgroup,
   output logic [1:0] o_rslot
);
   logic [71:0] store [logic [34:0]];
   logic [71:0] q_group [$];
   logic [1:0] q_slot [$];
   int q_due [$];
   int now = 0;
   initial begin
      o_rvalid = 1'b0;
      o_rgroup = '0;
      o_rslot = 2'b00;
   end
   always @(posedge i_clock) begin
      logic [34:0] key;
      key = {i_chan_b, i_second, i_addr};
      now++;
      o_rvalid <= 1'b0;
      // idle data lines never repeat the last group
      o_rgroup <= ~o_rgroup;
      if (i_valid && i_write) begin
         store[key] = i_wgroup;
      end else if (i_valid) begin
         // unwritten places read back as garbage, flips only when commanded
         q_group.push_back((store.exists(key) ? store[key] : '1) ^ i_flip);
         q_slot.push_back({i_chan_b, i_second});
         q_due.push_back(now + int'(i_delay));
      end else if (i_inj) begin
         // a zero-filled group as init left it, read back with the commanded flips
         q_group.push_back(i_flip);
         q_slot.push_back(i_inj_slot);
         q_due.push_back(now + int'(i_delay));
      end
      if (q_due.size() > 0 && q_due[0] <= now) begin
         o_rvalid <= 1'b1;
         o_rgroup <= q_group.pop_front();
         o_rslot <= q_slot.pop_front();
         void'(q_due.pop_front());
      end
   end
endmodule : dcie_dimm_model
`default_nettype wire

// File: dv/dual_channel_interleave_ecc_tb_top.sv
// self-checking bench for the dual channel interleave and ecc block
`timescale 1ns/1ps
`default_nettype none
module dual_channel_interleave_ecc_tb_top;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic [3:0] i_slot_present = 4'h0;
   logic [1:0] i_size_log2 = 2'b00;
   logic i_init_start = 1'b0;
   logic i_req_valid = 1'b0;
   logic i_req_write = 1'b0;
   logic [34:0] i_req_addr = '0;
   logic [63:0] i_req_wdata = '0;
   logic inj_valid = 1'b0;
   logic [1:0] inj_slot = 2'h0;
   logic [71:0] inj_flip = '0;
   logic o_init_done, o_config_error, o_req_ready, o_mem_valid, o_mem_write, o_mem_chan_b;
   logic o_mem_second_slot, i_mem_rvalid, o_rsp_valid, o_ce_pulse, o_ue_pulse;
   logic [1:0] o_mode, i_mem_rslot;
   logic [32:0] o_mem_addr;
   logic [71:0] o_mem_wgroup, i_mem_rgroup;
   logic [63:0] o_rsp_data;
   logic [3:0] o_ce_logged;
   int failures = 0;
   int n_compared = 0;
   dcie_ctrl uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_slot_present(i_slot_present),
      .i_size_log2(i_size_log2), .i_init_start(i_init_start), .o_init_done(o_init_done),
      .o_config_error(o_config_error), .o_mode(o_mode), .i_req_valid(i_req_valid),
      .i_req_write(i_req_write), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
      .o_req_ready(o_req_ready), .o_mem_valid(o_mem_valid), .o_mem_write(o_mem_write),
      .o_mem_chan_b(o_mem_chan_b), .o_mem_second_slot(o_mem_second_slot), .o_mem_addr(o_mem_addr),
      .o_mem_wgroup(o_mem_wgroup), .i_mem_rvalid(i_mem_rvalid), .i_mem_rgroup(i_mem_rgroup),
      .i_mem_rslot(i_mem_rslot), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
      .o_ce_pulse(o_ce_pulse), .o_ue_pulse(o_ue_pulse), .o_ce_logged(o_ce_logged));
   dcie_dimm_model dimms (.i_clock(i_clock), .i_valid(o_mem_valid), .i_write(o_mem_write),
      .i_chan_b(o_mem_chan_b), .i_second(o_mem_second_slot), .i_addr(o_mem_addr),
      .i_wgroup(o_mem_wgroup), .i_delay(4'h0), .i_flip(inj_flip), .i_inj(inj_valid),
      .i_inj_slot(inj_slot), .o_rvalid(i_mem_rvalid), .o_rgroup(i_mem_rgroup), .o_rslot(i_mem_rslot));
   initial begin
      forever #12.5 i_clock = ~i_clock;
   end
   task automatic cmp_vec(input logic [71:0] got, input logic [71:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_vec
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   task automatic do_reset(input logic [3:0] pres);
      i_rst_n = 1'b0;
      i_slot_present = pres;
      repeat (16) @(negedge i_clock);
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_clock);
   endtask : do_reset
   // every population, valid or not, against the mode it must select
   task automatic mode_check;
      logic [1:0] na;
      logic [1:0] nb;
      logic bad;
      logic [1:0] em;
      for (int p = 0; p < 16; p++) begin
         i_slot_present = 4'(p);
         repeat (4) @(negedge i_clock);
         na = 2'(p[0]) + 2'(p[1]);
         nb = 2'(p[2]) + 2'(p[3]);
         bad = (p[1] & !p[0]) | (p[3] & !p[2]);
         em = (bad || na + nb == 0) ? dcie_pkg::DCIE_MODE_NONE :
            (na == 0 || nb == 0) ? dcie_pkg::DCIE_MODE_SINGLE :
            (na == nb) ? dcie_pkg::DCIE_MODE_SYMMETRIC : dcie_pkg::DCIE_MODE_SPLIT;
         cmp_vec(72'(o_config_error), 72'(bad));
         cmp_vec(72'(o_mode), 72'(em));
      end
   endtask : mode_check
   // second slot alone: fill must never start
   task automatic refuse_check;
      do_reset(4'b0010);
      i_init_start = 1'b1;
      repeat (20) begin
         @(negedge i_clock);
         cmp_vec(72'(o_mem_valid), 72'h00_0000_0000_0000_0000);
      end
      cmp_vec(72'(o_init_done), 72'h00_0000_0000_0000_0000);
      i_init_start = 1'b0;
   endtask : refuse_check
   // a full fill of even one module is millions of cycles, so only its opening lines
   // are judged here and traffic after init stays to the in-design assertions
   task automatic fill_check(input logic [3:0] pres, input bit sym, input bit chan, input int lines);
      int k;
      int t;
      logic [32:0] ea;
      k = 0;
      t = 0;
      do_reset(pres);
      i_init_start = 1'b1;
      // a pending write must not slip in among the zero fill
      i_req_valid = 1'b1;
      i_req_write = 1'b1;
      i_req_wdata = 64'h5a5a_5a5a_5a5a_5a5a;
      while (k < lines && t < 300) begin
         @(negedge i_clock);
         t++;
         i_init_start = 1'b0;
         if (o_mem_valid === 1'b1) begin
            ea = sym ? 33'(k / 2) << 6 : 33'(k) << 6;
            cmp_vec(72'(o_mem_write), 72'h00_0000_0000_0000_0001);
            cmp_vec(72'(o_mem_chan_b), 72'(sym ? k[0] : chan));
            cmp_vec(72'(o_mem_addr), 72'(ea));
            cmp_vec(72'(o_mem_second_slot), 72'h00_0000_0000_0000_0000);
            cmp_vec(o_mem_wgroup, '0);
            cmp_vec(72'(o_req_ready), 72'h00_0000_0000_0000_0000);
            k++;
         end
      end
      cmp_vec(72'(k), 72'(lines));
      i_req_valid = 1'b0;
   endtask : fill_check
   // one read of a zero-filled group through the modules, with chosen bits flipped
   task automatic ecc_read(input logic [71:0] flip, input logic [1:0] slot);
      inj_valid = 1'b1;
      inj_flip = flip;
      inj_slot = slot;
      @(negedge i_clock);
      inj_valid = 1'b0;
      @(negedge i_clock);
      cmp_vec(72'(o_rsp_valid), 72'h00_0000_0000_0000_0001);
   endtask : ecc_read
   // zero groups are code words, so every flip pattern has a known outcome
   task automatic ecc_check;
      int n_ce [4];
      logic [71:0] flip;
      logic [3:0] exp_log;
      n_ce = '{0, 0, 0, 0};
      do_reset(4'h0);
      ecc_read(72'h00_0000_0000_0000_0000, 2'h0);
      cmp_vec(72'(o_rsp_data), 72'h00_0000_0000_0000_0000);
      cmp_vec(72'({o_ce_pulse, o_ue_pulse}), 72'h00_0000_0000_0000_0000);
      // twenty single flips per slot: two threshold events each
      for (int i = 0; i < 80; i++) begin
         flip = 72'h00_0000_0000_0000_0001 << (i % 72);
         n_ce[i % 4]++;
         exp_log = (n_ce[i % 4] % int'(dcie_pkg::CE_THRESHOLD) == 0) ? 4'h1 << (i % 4) : 4'h0;
         ecc_read(flip, 2'(i % 4));
         cmp_vec(72'(o_rsp_data), 72'h00_0000_0000_0000_0000);
         cmp_vec(72'({o_ce_pulse, o_ue_pulse}), 72'h00_0000_0000_0000_0002);
         cmp_vec(72'(o_ce_logged), 72'(exp_log));
      end
      for (int i = 0; i < 72; i++) begin
         flip = (72'h00_0000_0000_0000_0001 << i) | (72'h00_0000_0000_0000_0001 << ((i + 29) % 72));
         ecc_read(flip, 2'h0);
         cmp_vec(72'(o_rsp_data), 72'(flip[63:0]));
         cmp_vec(72'({o_ce_pulse, o_ue_pulse}), 72'h00_0000_0000_0000_0001);
         cmp_vec(72'(o_ce_logged), 72'h00_0000_0000_0000_0000);
      end
   endtask : ecc_check
   initial begin
      do_reset(4'h0);
      mode_check();
      refuse_check();
      fill_check(4'b0001, 1'b0, 1'b0, 40);
      fill_check(4'b0100, 1'b0, 1'b1, 40);
      fill_check(4'b0101, 1'b1, 1'b0, 40);
      fill_check(4'b1111, 1'b1, 1'b0, 40);
      ecc_check();
      end_of_test();
   end
   initial begin
      repeat (5000) @(posedge i_clock);
      failures++;
      end_of_test();
   end
endmodule : dual_channel_interleave_ecc_tb_top
`default_nettype wire
